// [verilog/mleu_pkg.sv]
// Function
// - Round multiply: low source byte times destination, plus 80h, bits 23:8 written
// - Round multiply ignores source high byte; source register unchanged
// - Round multiply: six hold cycles, prefetch in seventh
// - Multiplies set Z on zero product, N from top bit, clear C, V
// - Multiply flags judged at 16 bits for byte, 32 for word
// - Signed byte multiply: signed low bytes, 16-bit product to destination
// - Signed word multiply: high half to upper register, low to destination
// - Upper register written first; low half wins if destination is upper
// - Signed overflow: bits 15:7 or 31:15 unequal; later check reports
// - Unsigned overflow: bits 15:8 or 31:16 nonzero; later check reports
// - Unsigned byte and word multiplies, same result placement
// - Each multiply variant has its own opcode
// - Signed word multiply ends cycle 13, or 14 for negative destination
// - No-op: one cycle, flags untouched, only instruction and last bus addresses advance
// - Byte complement works on zero-extended word; high byte all ones
// - OR in four forms, each with word and byte opcodes
// - Byte OR high byte zero; memory destination takes low byte
// - OR and complement: Z, N at size, C kept, V cleared
package mleu_pkg;
	localparam logic [7:0] OP_MULU_W = 8'hA4;
	localparam logic [7:0] OP_MULU_B = 8'hA5;
	localparam logic [7:0] OP_MULS_W = 8'hA6;
	localparam logic [7:0] OP_MULS_B = 8'hA7;
	localparam logic [7:0] OP_BWR    = 8'hAC;
	localparam logic [7:0] OP_NOP    = 8'h92;
	localparam logic [7:0] OP_NOT_W  = 8'h2C;
	localparam logic [7:0] OP_NOT_B  = 8'h2D;
	localparam logic [7:0] OP_OR_LO  = 8'h48;
	localparam logic [7:0] OP_OR_HI  = 8'h4F;
	localparam logic [23:0] ROUND_K  = 24'h000080;
	localparam logic [15:0] ZERO_REG = 16'h0000;
	localparam logic [4:0] CYC_BWR   = 5'h07;
	localparam logic [4:0] CYC_MSW   = 5'h0D;
	localparam logic [4:0] CYC_MSB   = 5'h0A;
	localparam logic [4:0] CYC_MUW   = 5'h0D;
	localparam logic [4:0] CYC_MUB   = 5'h08;
	localparam logic [4:0] CYC_ONE   = 5'h01;
	localparam logic [15:0] PF_OFS   = 16'h0004;
	localparam logic [15:0] IA_STEP  = 16'h0002;
	localparam logic [7:0] A_CTRL    = 8'h00;
	localparam logic [7:0] A_SRC     = 8'h04;
	localparam logic [7:0] A_DST     = 8'h08;
	localparam logic [7:0] A_UPR     = 8'h0C;
	localparam logic [7:0] A_FLAG    = 8'h10;
	localparam logic [7:0] A_STAT    = 8'h14;
	localparam logic [7:0] A_IADDR   = 8'h18;
	localparam logic [7:0] A_LADDR   = 8'h1C;
	localparam logic [7:0] A_MEM     = 8'h20;
	localparam int CTL_DUPR = 8;
	localparam int CTL_GO   = 31;
	localparam logic [1:0] RESP_OK  = 2'h0;
	localparam logic [1:0] RESP_ERR = 2'h2;
	typedef struct packed {
		logic v;
		logic c;
		logic n;
		logic z;
	} mleu_flag_type;
	typedef struct packed {
		logic uovf;
		logic sovf;
		logic illegal;
		logic busy;
	} mleu_stat_type;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_RUN  = 2'b10
	} mleu_state_type;
endpackage

// [verilog/mleu_core.sv]
// Chosen here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
module mleu_core
	import mleu_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	input  wire logic              clock,
	input  wire logic              rst,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic [2:0]        s_axi_awprot,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic [2:0]        s_axi_arprot,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	output logic                   hold_fetch,
	output logic                   prefetch_word,
	output logic [15:0]            bus_addr,
	output logic                   mem_wr,
	output logic [7:0]             mem_strb
);

	if (ADDR_W < 6 || ADDR_W > 16) begin : g_addr_chk
		$error("ADDR_W out of range");
	end

	mleu_state_type state_q;
	mleu_flag_type  flag_word_q;
	mleu_flag_type  flag_d;
	mleu_stat_type  stat_q;
	logic [7:0]  opcode_q;
	logic        dst_upr_q;
	logic [15:0] source_reg_q;
	logic [15:0] dest_q;
	logic [15:0] upper_product_reg_q;
	logic [15:0] instr_addr_q;
	logic [15:0] last_bus_addr_q;
	logic [15:0] mem_data_q;
	logic [4:0]  cnt_q;
	logic        aw_full_q;
	logic        w_full_q;
	logic [7:0]  aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0]  w_strb_q;
	logic        wr_go;
	logic        wr_ok;
	logic        last_cyc;
	logic [31:0] prod;
	logic [15:0] dst_d;
	logic [15:0] upr_d;
	logic        dst_we;
	logic        upr_we;
	logic        mem_d;
	logic        illegal_d;
	logic        sovf_d;
	logic        uovf_d;
	logic [31:0] rd_d;
	logic        rd_ok;

	function automatic logic [4:0] op_cycles(input logic [7:0] op,
		input logic [15:0] d);
		logic [4:0] c;
		c = CYC_ONE;
		case (op)
			OP_BWR:    c = CYC_BWR;
			OP_MULS_W: c = d[15] ? CYC_MSW + 5'h01 : CYC_MSW;
			OP_MULS_B: c = d[7] ? CYC_MSB + 5'h01 : CYC_MSB;
			OP_MULU_W: c = CYC_MUW;
			OP_MULU_B: c = CYC_MUB;
			default:   c = CYC_ONE;
		endcase
		return c;
	endfunction

	function automatic logic [15:0] merge(input logic [15:0] old,
		input logic [31:0] wd, input logic [3:0] st);
		logic [15:0] r;
		r = old;
		if (st[0]) begin
			r[7:0] = wd[7:0];
		end
		if (st[1]) begin
			r[15:8] = wd[15:8];
		end
		return r;
	endfunction

	function automatic logic is_or(input logic [7:0] op);
		return op >= OP_OR_LO && op <= OP_OR_HI;
	endfunction

	// AXI4-Lite write channels
	assign s_axi_awready = !aw_full_q && !s_axi_bvalid;
	assign s_axi_wready  = !w_full_q && !s_axi_bvalid;
	assign wr_go = aw_full_q && w_full_q && !s_axi_bvalid;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			aw_full_q <= 1'b0;
			w_full_q  <= 1'b0;
			aw_addr_q <= 8'h00;
			w_data_q  <= 32'h0000_0000;
			w_strb_q  <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_full_q <= 1'b1;
				aw_addr_q <= 8'(s_axi_awaddr);
			end else if (wr_go) begin
				aw_full_q <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_full_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end else if (wr_go) begin
				w_full_q <= 1'b0;
			end
		end
	end

	always_comb begin
		wr_ok = 1'b1;
		if (aw_addr_q == A_CTRL || aw_addr_q == A_SRC) begin
			wr_ok = 1'b1;
		end else if (aw_addr_q == A_DST || aw_addr_q == A_UPR) begin
			wr_ok = 1'b1;
		end else if (aw_addr_q == A_FLAG || aw_addr_q == A_IADDR) begin
			wr_ok = 1'b1;
		end else if (aw_addr_q == A_LADDR || aw_addr_q == A_STAT) begin
			wr_ok = 1'b1;
		end else if (aw_addr_q == A_MEM) begin
			wr_ok = 1'b1;
		end else begin
			wr_ok = 1'b0;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OK;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_ok ? RESP_OK : RESP_ERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Execution datapath
	always_comb begin
		prod      = 32'h0000_0000;
		dst_d     = dest_q;
		upr_d     = upper_product_reg_q;
		dst_we    = 1'b0;
		upr_we    = 1'b0;
		mem_d     = 1'b0;
		flag_d    = flag_word_q;
		illegal_d = 1'b0;
		sovf_d    = stat_q.sovf;
		uovf_d    = stat_q.uovf;
		case (opcode_q)
			OP_BWR: begin
				prod[23:0] = 24'(source_reg_q[7:0]) * 24'(dest_q) +
					ROUND_K;
				dst_d  = prod[23:8];
				dst_we = 1'b1;
				flag_d = '{v: 1'b0, c: 1'b0, n: prod[23],
					z: prod[23:8] == 16'h0000};
			end
			OP_MULS_B: begin
				prod[15:0] = 16'($signed(source_reg_q[7:0])) *
					16'($signed(dest_q[7:0]));
				dst_d  = prod[15:0];
				dst_we = 1'b1;
				flag_d = '{v: 1'b0, c: 1'b0, n: prod[15],
					z: prod[15:0] == 16'h0000};
				sovf_d = !(&prod[15:7] || ~|prod[15:7]);
			end
			OP_MULU_B: begin
				prod[15:0] = 16'(source_reg_q[7:0]) *
					16'(dest_q[7:0]);
				dst_d  = prod[15:0];
				dst_we = 1'b1;
				flag_d = '{v: 1'b0, c: 1'b0, n: prod[15],
					z: prod[15:0] == 16'h0000};
				uovf_d = |prod[15:8];
			end
			OP_MULS_W, OP_MULU_W: begin
				if (opcode_q == OP_MULS_W) begin
					prod = 32'($signed(source_reg_q)) *
						32'($signed(dest_q));
					sovf_d = !(&prod[31:15] || ~|prod[31:15]);
				end else begin
					prod = 32'(source_reg_q) * 32'(dest_q);
					uovf_d = |prod[31:16];
				end
				upr_d  = dst_upr_q ? prod[15:0] : prod[31:16];
				upr_we = 1'b1;
				dst_d  = prod[15:0];
				dst_we = !dst_upr_q;
				flag_d = '{v: 1'b0, c: 1'b0, n: prod[31],
					z: prod == 32'h0000_0000};
			end
			OP_NOP: begin
				dst_we = 1'b0;
			end
			OP_NOT_W, OP_NOT_B: begin
				if (opcode_q == OP_NOT_B) begin
					prod[15:0] = ~(ZERO_REG ^ {8'h00, dest_q[7:0]});
					flag_d.z = prod[7:0] == 8'h00;
					flag_d.n = prod[7];
				end else begin
					prod[15:0] = ~(ZERO_REG ^ dest_q);
					flag_d.z = prod[15:0] == 16'h0000;
					flag_d.n = prod[15];
				end
				flag_d.v = 1'b0;
				dst_d  = prod[15:0];
				dst_we = 1'b1;
			end
			default: begin
				if (is_or(opcode_q)) begin
					if (opcode_q[0]) begin
						prod[15:0] = {8'h00, source_reg_q[7:0] |
							dest_q[7:0]};
						flag_d.z = prod[7:0] == 8'h00;
						flag_d.n = prod[7];
					end else begin
						prod[15:0] = source_reg_q | dest_q;
						flag_d.z = prod[15:0] == 16'h0000;
						flag_d.n = prod[15];
					end
					flag_d.v = 1'b0;
					mem_d  = opcode_q[1];
					dst_d  = prod[15:0];
					dst_we = !opcode_q[1];
				end else begin
					illegal_d = 1'b1;
				end
			end
		endcase
	end

	// Sequencer
	assign last_cyc = state_q == ST_RUN && cnt_q == 5'h01;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_q <= ST_IDLE;
			cnt_q   <= 5'h00;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (wr_go && aw_addr_q == A_CTRL && w_strb_q[3] &&
						w_data_q[CTL_GO]) begin
						state_q <= ST_RUN;
						cnt_q   <= op_cycles(w_strb_q[0] ? w_data_q[7:0] :
							opcode_q, dest_q);
					end
				end
				ST_RUN: begin
					cnt_q <= cnt_q - 5'h01;
					if (cnt_q == 5'h01) begin
						state_q <= ST_IDLE;
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	assign hold_fetch    = state_q == ST_RUN && !last_cyc;
	assign prefetch_word = last_cyc;
	assign bus_addr      = hold_fetch ? last_bus_addr_q :
		16'(instr_addr_q + PF_OFS);
	assign mem_strb      = mem_data_q[7:0];

	// Software registers and write-back
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			opcode_q            <= OP_NOP;
			dst_upr_q           <= 1'b0;
			source_reg_q        <= 16'h0000;
			dest_q              <= 16'h0000;
			upper_product_reg_q <= 16'h0000;
			flag_word_q         <= '0;
			instr_addr_q        <= 16'h0000;
			last_bus_addr_q     <= 16'h0000;
			mem_data_q          <= 16'h0000;
			mem_wr              <= 1'b0;
			stat_q              <= '0;
		end else begin
			mem_wr <= 1'b0;
			if (last_cyc) begin
				if (upr_we) begin
					upper_product_reg_q <= upr_d;
				end
				if (dst_we) begin
					dest_q <= dst_d;
				end
				if (!illegal_d) begin
					flag_word_q <= flag_d;
				end
				if (mem_d) begin
					mem_data_q <= opcode_q[0] ? {8'h00, dst_d[7:0]} :
						dst_d;
					mem_wr <= 1'b1;
				end
				stat_q.illegal <= illegal_d;
				stat_q.sovf    <= sovf_d;
				stat_q.uovf    <= uovf_d;
				instr_addr_q    <= 16'(instr_addr_q + IA_STEP);
				last_bus_addr_q <= 16'(instr_addr_q + PF_OFS);
			end else if (wr_go && state_q == ST_IDLE) begin
				if (aw_addr_q == A_CTRL) begin
					if (w_strb_q[0]) begin
						opcode_q <= w_data_q[7:0];
					end
					if (w_strb_q[1]) begin
						dst_upr_q <= w_data_q[CTL_DUPR];
					end
				end else if (aw_addr_q == A_SRC) begin
					source_reg_q <= merge(source_reg_q, w_data_q, w_strb_q);
				end else if (aw_addr_q == A_DST) begin
					dest_q <= merge(dest_q, w_data_q, w_strb_q);
				end else if (aw_addr_q == A_UPR) begin
					upper_product_reg_q <= merge(upper_product_reg_q,
						w_data_q, w_strb_q);
				end else if (aw_addr_q == A_FLAG && w_strb_q[0]) begin
					flag_word_q <= w_data_q[3:0];
				end else if (aw_addr_q == A_IADDR) begin
					instr_addr_q <= merge(instr_addr_q, w_data_q, w_strb_q);
				end else if (aw_addr_q == A_LADDR) begin
					last_bus_addr_q <= merge(last_bus_addr_q, w_data_q,
						w_strb_q);
				end else if (aw_addr_q == A_STAT && w_strb_q[0]) begin
					stat_q.illegal <= 1'b0;
					stat_q.sovf    <= 1'b0;
					stat_q.uovf    <= 1'b0;
				end
			end
			stat_q.busy <= state_q == ST_RUN && !last_cyc;
		end
	end

	// AXI4-Lite read channel
	assign s_axi_arready = !s_axi_rvalid;

	always_comb begin
		rd_d  = 32'h0000_0000;
		rd_ok = 1'b1;
		if (8'(s_axi_araddr) == A_CTRL) begin
			rd_d = {23'h000000, dst_upr_q, opcode_q};
		end else if (8'(s_axi_araddr) == A_SRC) begin
			rd_d = {16'h0000, source_reg_q};
		end else if (8'(s_axi_araddr) == A_DST) begin
			rd_d = {16'h0000, dest_q};
		end else if (8'(s_axi_araddr) == A_UPR) begin
			rd_d = {16'h0000, upper_product_reg_q};
		end else if (8'(s_axi_araddr) == A_FLAG) begin
			rd_d = {28'h0000000, flag_word_q};
		end else if (8'(s_axi_araddr) == A_STAT) begin
			rd_d = {28'h0000000, stat_q};
		end else if (8'(s_axi_araddr) == A_IADDR) begin
			rd_d = {16'h0000, instr_addr_q};
		end else if (8'(s_axi_araddr) == A_LADDR) begin
			rd_d = {16'h0000, last_bus_addr_q};
		end else if (8'(s_axi_araddr) == A_MEM) begin
			rd_d = {16'h0000, mem_data_q};
		end else begin
			rd_ok = 1'b0;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= RESP_OK;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_d;
			s_axi_rresp  <= rd_ok ? RESP_OK : RESP_ERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// Checks
	a_bwr_seven: assert property (@(posedge clock) disable iff (rst)
		$rose(state_q == ST_RUN) && opcode_q == OP_BWR |->
		hold_fetch [*6] ##1 prefetch_word)
		else $error("round multiply not seven cycles");

	a_msw_len: assert property (@(posedge clock) disable iff (rst)
		$rose(state_q == ST_RUN) && opcode_q == OP_MULS_W && !dest_q[15]
		|-> ##12 prefetch_word)
		else $error("signed word multiply length wrong");

	a_hold_addr: assert property (@(posedge clock) disable iff (rst)
		hold_fetch |-> bus_addr == last_bus_addr_q && !prefetch_word &&
		(!$past(hold_fetch) || $stable(bus_addr)))
		else $error("bus left previous address");

	a_mul_cv: assert property (@(posedge clock) disable iff (rst)
		prefetch_word && (opcode_q == OP_MULU_W || opcode_q == OP_BWR)
		|=> !flag_word_q.c && !flag_word_q.v)
		else $error("multiply left C or V set");

	a_bwr_res: assert property (@(posedge clock) disable iff (rst)
		prefetch_word && opcode_q == OP_BWR |=> dest_q ==
		16'((24'(8'($past(source_reg_q))) * 24'($past(dest_q)) +
		ROUND_K) >> 8))
		else $error("round multiply result wrong");

	a_src_kept: assert property (@(posedge clock) disable iff (rst)
		state_q == ST_RUN |=> $stable(source_reg_q))
		else $error("source register changed");

	a_upr_dst: assert property (@(posedge clock) disable iff (rst)
		prefetch_word && (opcode_q == OP_MULU_W ||
		opcode_q == OP_MULS_W) && dst_upr_q |=>
		upper_product_reg_q == 16'($past(source_reg_q) * $past(dest_q)))
		else $error("upper register not low half");

	a_nop_flags: assert property (@(posedge clock) disable iff (rst)
		prefetch_word && opcode_q == OP_NOP |=> $stable(flag_word_q) &&
		$stable(dest_q))
		else $error("no-op changed state");

	a_notb_high: assert property (@(posedge clock) disable iff (rst)
		prefetch_word && opcode_q == OP_NOT_B |=> dest_q[15:8] == 8'hFF)
		else $error("byte complement high byte wrong");

	a_or_carry: assert property (@(posedge clock) disable iff (rst)
		prefetch_word && is_or(opcode_q) |=> !flag_word_q.v &&
		flag_word_q.c == $past(flag_word_q.c))
		else $error("OR changed carry or left V");

endmodule

// [test/testbench.sv]
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
	tests_run++; \
	if ((g) !== (e)) begin \
		mismatches++; \
		$display("MISMATCH %s exp %0h got %0h", nm, e, g); \
	end \
end
module testbench
	import mleu_pkg::*;
;
	logic        clock = 1'h0;
	logic        rst = 1'h1;
	logic [7:0]  s_axi_awaddr = 8'h00;
	logic [7:0]  s_axi_araddr = 8'h00;
	logic [2:0]  s_axi_awprot = 3'h0;
	logic [2:0]  s_axi_arprot = 3'h0;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [31:0] s_axi_rdata;
	logic        s_axi_awvalid = 1'h0;
	logic        s_axi_wvalid = 1'h0;
	logic        s_axi_bready = 1'h0;
	logic        s_axi_arvalid = 1'h0;
	logic        s_axi_rready = 1'h0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic        s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        hold_fetch, prefetch_word, mem_wr;
	logic [15:0] bus_addr, last_a, pf_addr;
	logic [7:0]  mem_strb, strb_seen;
	int          mismatches = 0;
	int          tests_run = 0;
	int          hold_n = 0, pf_n = 0, bad_n = 0, wr_n = 0;

	always #4 clock = ~clock;

	mleu_core mleu_core_i (
		.clock, .rst, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.hold_fetch, .prefetch_word, .bus_addr, .mem_wr, .mem_strb
	);

	// Watches the fetch side: hold length, held address, pulses
	always @(posedge clock) begin
		if (hold_fetch === 1'h1) begin
			hold_n <= hold_n + 1;
			if (bus_addr !== last_a)
				bad_n <= bad_n + 1;
		end
		if (prefetch_word === 1'h1) begin
			pf_n <= pf_n + 1;
			pf_addr <= bus_addr;
		end
		if (mem_wr === 1'h1) begin
			wr_n <= wr_n + 1;
			strb_seen <= mem_strb;
		end
	end

	task automatic complete_run();
		if (mismatches == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		int n;
		logic ta, tw, tb;
		n = 0;
		tb = 1'h0;
		@(posedge clock);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		while (!tb) begin
			@(posedge clock);
			ta = s_axi_awvalid && s_axi_awready;
			tw = s_axi_wvalid && s_axi_wready;
			tb = s_axi_bvalid === 1'h1;
			r = s_axi_bresp;
			if (ta)
				s_axi_awvalid <= 1'h0;
			if (tw)
				s_axi_wvalid <= 1'h0;
			if (tb)
				s_axi_bready <= 1'h0;
			n++;
			if (n > 50) begin
				mismatches++;
				complete_run();
			end
		end
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		int n;
		logic ta, tb;
		n = 0;
		tb = 1'h0;
		@(posedge clock);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		while (!tb) begin
			@(posedge clock);
			ta = s_axi_arvalid && s_axi_arready;
			tb = s_axi_rvalid === 1'h1;
			d = s_axi_rdata;
			r = s_axi_rresp;
			if (ta)
				s_axi_arvalid <= 1'h0;
			if (tb)
				s_axi_rready <= 1'h0;
			n++;
			if (n > 50) begin
				mismatches++;
				complete_run();
			end
		end
	endtask

	task automatic ck(input logic [7:0] a, input string nm,
		input logic [15:0] e);
		logic [31:0] d;
		logic [1:0]  r;
		rd(a, d, r);
		`CHK(nm, {16'h0, e}, d)
	endtask

	// Loads operands, starts one instruction, times it
	task automatic run(input logic [8:0] op, input logic [15:0] s, dv,
		input logic [3:0] f, input int cyc);
		logic [31:0] d;
		logic [1:0]  r;
		logic [15:0] ia;
		int          h, p, b, n;
		wr(A_SRC, {16'h0, s}, r);
		wr(A_DST, {16'h0, dv}, r);
		wr(A_UPR, {16'h0, dv}, r);
		wr(A_FLAG, {28'h0, f}, r);
		wr(A_STAT, 32'h0000000E, r);
		rd(A_LADDR, d, r);
		last_a = d[15:0];
		rd(A_IADDR, d, r);
		ia = d[15:0];
		h = hold_n;
		p = pf_n;
		b = bad_n;
		n = 0;
		wr(A_CTRL, {23'h0, op}, r);
		wr(A_CTRL, {1'h1, 22'h0, op}, r);
		while (pf_n == p) begin
			@(posedge clock);
			n++;
			if (n > 40) begin
				mismatches++;
				complete_run();
			end
		end
		@(posedge clock);
		`CHK("cycles", cyc, hold_n - h + 1)
		`CHK("pf_count", p + 1, pf_n)
		`CHK("held_addr", b, bad_n)
		`CHK("pf_addr", ia + PF_OFS, pf_addr)
		ck(A_IADDR, "iaddr", ia + IA_STEP);
	endtask

	task automatic mres(input logic [15:0] ed, eu, input logic [3:0] ef,
		input logic [4:0] es);
		ck(A_DST, "dst", ed);
		ck(A_UPR, "upr", eu);
		ck(A_FLAG, "flags", {12'h0, ef});
		if (!es[4])
			ck(A_STAT, "status", {12'h0, es[3:0]});
	endtask

	task automatic t_bus();
		logic [31:0] d;
		logic [1:0]  r;
		`CHK("idle_hold", 1'h0, hold_fetch)
		wr(8'h40, 32'h0000FFFF, r);
		`CHK("wr_resp", RESP_ERR, r)
		rd(8'h40, d, r);
		`CHK("rd_resp", RESP_ERR, r)
		`CHK("rd_data", 32'h0, d)
		wr(A_SRC, 32'h0000ABCD, r);
		`CHK("ok_resp", RESP_OK, r)
		ck(A_SRC, "src", 16'hABCD);
	endtask

	task automatic t_round();
		run({1'h0, OP_BWR}, 16'hAB12, 16'h1234, 4'hF, 7);
		mres(16'h0148, 16'h1234, 4'h0, 5'h10);
		ck(A_SRC, "bwr_src", 16'hAB12);
		run({1'h0, OP_BWR}, 16'h00FF, 16'hFFFF, 4'h0, 7);
		mres(16'hFEFF, 16'hFFFF, 4'h2, 5'h10);
	endtask

	task automatic t_signed();
		run({1'h0, OP_MULS_W}, 16'hFFFE, 16'h8000, 4'hF, 14);
		mres(16'h0000, 16'h0001, 4'h0, 5'h04);
		run({1'h0, OP_MULS_W}, 16'h8000, 16'h0001, 4'h0, 13);
		mres(16'h8000, 16'hFFFF, 4'h2, 5'h00);
		run({1'h1, OP_MULS_W}, 16'h0003, 16'h0100, 4'h0, 13);
		mres(16'h0100, 16'h0300, 4'h0, 5'h10);
		run({1'h0, OP_MULS_B}, 16'h3380, 16'h55FF, 4'hF, 11);
		mres(16'h0080, 16'h55FF, 4'h0, 5'h04);
		run({1'h0, OP_MULS_B}, 16'h00FF, 16'h0002, 4'h0, 10);
		mres(16'hFFFE, 16'h0002, 4'h2, 5'h00);
	endtask

	task automatic t_unsigned();
		run({1'h0, OP_MULU_B}, 16'h00FF, 16'h00FF, 4'hF, 8);
		mres(16'hFE01, 16'h00FF, 4'h2, 5'h08);
		run({1'h0, OP_MULU_B}, 16'h1200, 16'h3400, 4'h0, 8);
		mres(16'h0000, 16'h3400, 4'h1, 5'h00);
		run({1'h0, OP_MULU_W}, 16'hFFFF, 16'hFFFF, 4'h0, 13);
		mres(16'h0001, 16'hFFFE, 4'h2, 5'h08);
	endtask

	task automatic t_misc();
		run({1'h0, OP_NOP}, 16'h1111, 16'h2222, 4'hA, 1);
		mres(16'h2222, 16'h2222, 4'hA, 5'h00);
		ck(A_SRC, "nop_src", 16'h1111);
		run({1'h0, OP_NOT_W}, 16'h0000, 16'h00FF, 4'hF, 1);
		mres(16'hFF00, 16'h00FF, 4'h6, 5'h10);
		run({1'h0, OP_NOT_B}, 16'h0000, 16'h12FF, 4'hF, 1);
		mres(16'hFF00, 16'h12FF, 4'h5, 5'h10);
		run({1'h0, 8'h00}, 16'h0000, 16'h0000, 4'h0, 1);
		ck(A_STAT, "illegal", 16'h0002);
	endtask

	task automatic t_or();
		int          i, w;
		logic [7:0]  op;
		logic [15:0] e;
		for (i = 0; i < 8; i++) begin
			op = OP_OR_LO + 8'(i);
			e = op[0] ? 16'h0081 : 16'h3F81;
			w = wr_n;
			run({1'h0, op}, 16'h0F80, 16'h3401, 4'hC, 1);
			mres(op[1] ? 16'h3401 : e, 16'h3401,
				{2'h1, op[0], 1'h0}, 5'h10);
			`CHK("or_mem_wr", w + op[1], wr_n)
			if (op[1]) begin
				`CHK("or_strb", e[7:0], strb_seen)
				ck(A_MEM, "or_mem", e);
			end
		end
	endtask

	initial begin
		repeat (8) @(posedge clock);
		rst <= 1'h0;
		t_bus();
		t_round();
		t_signed();
		t_unsigned();
		t_misc();
		t_or();
		complete_run();
	end
endmodule
